/* File: inc/trip_pkg.sv */
`default_nettype none
package trip_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    // times in milliseconds
    localparam int unsigned RESET_DELAY_MS = 1000;
    localparam int unsigned EXT_RESET_DELAY_MS = 10000;
    localparam int unsigned OVERHEAT_STOP_MS = 10000;
    localparam int unsigned ALARM_FLASH_MS = 640;
    localparam int unsigned PROG_FLASH_MS = 10000;
    localparam longint unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam longint unsigned RESET_DELAY_CYC = RESET_DELAY_MS * CYC_PER_MS;
    localparam longint unsigned EXT_RESET_DELAY_CYC = EXT_RESET_DELAY_MS * CYC_PER_MS;
    localparam longint unsigned OVERHEAT_STOP_CYC = OVERHEAT_STOP_MS * CYC_PER_MS;
    localparam longint unsigned ALARM_FLASH_CYC = ALARM_FLASH_MS * CYC_PER_MS;
    localparam longint unsigned PROG_FLASH_CYC = PROG_FLASH_MS * CYC_PER_MS;
    // alarm threshold, per mille of trip value
    localparam int unsigned ALARM_PERMILLE = 750;
    localparam int unsigned LOAD_FULL_PCT = 100;
    localparam int unsigned STOP_ON_TRIP_BIT = 0;
    localparam logic [2:0] PRIO_NONE = 3'h7;
    localparam logic [2:0] PRIO_HW = 3'h1;
    localparam logic [2:0] PRIO_NONRESET = 3'h2;
    localparam logic [2:0] PRIO_NVDATA = 3'h3;
    localparam logic [2:0] PRIO_CARD = 3'h4;
    localparam logic [2:0] PRIO_CARD_PWRUP = 3'h5;
    localparam logic [2:0] PRIO_ENC_SUPPLY = 3'h4;
    localparam logic [2:0] PRIO_NORMAL = 3'h5;
    localparam logic [2:0] PRIO_UNDERVOLT = 3'h6;

    // one bit per trip source except undervoltage, which comes from the supply inputs
    typedef struct packed {
        logic internal_hardware_fault;
        logic nonresettable_fault;
        logic nonvolatile_data_error_trip;
        logic card_trip;
        logic encoder_supply_trip;
        logic extended_reset_trip;
        logic encoder_feedback_trip;
        logic normal_trip;
        logic non_important_trip;
        logic phase_loss_trip;
        logic thermal_model_overheat_trip;
    } trip_req_t;

    typedef enum logic [3:0] {
        SRC_NONE, SRC_HW, SRC_NONRESET, SRC_NVDATA, SRC_CARD, SRC_ENC_SUPPLY,
        SRC_EXT_RESET, SRC_ENC_FEEDBACK, SRC_NORMAL, SRC_NON_IMPORTANT,
        SRC_PHASE_LOSS, SRC_OVERHEAT, SRC_UNDERVOLT
    } trip_src_t;

    typedef struct packed {
        logic braking_resistor_overload_alarm;
        logic motor_overload_alarm;
        logic program_running_alarm;
    } alarm_t;
endpackage
`default_nettype wire

/* File: design/trip_priority_manager.sv */
// Behaviour
// RQ1: accept trip only over larger priority number
// RQ2: priority 1 hardware faults never clear
// RQ3: priority 2 faults never clear
// RQ4: nonvolatile error clears only after defaults code
// RQ5: card trips priority 4, 5 at power-up
// RQ6: encoder supply overrides only encoder feedback trips
// RQ7: extended reset trips clear after 10 s
// RQ8: other trips clear after 1 s
// RQ9: non-important trips stop first when configured
// RQ10: phase loss stops motor before tripping
// RQ11: overheat stops, trips after 10 s anyway
// RQ12: undervoltage priority 6, self-clearing only
// RQ13: undervoltage blocks drive enable only
// RQ14: undervoltage save unless low-voltage supply mode
// RQ15: supply restored clears only undervoltage trip
// RQ16: supply switching only during undervoltage condition
// RQ17: undervoltage shown only with no other trip
// RQ18: power-up undervoltage without parameter save
// RQ19: alarms flash 640 ms, program alarm 10 s
// RQ20: no alarms while editing a parameter
// RQ21: resistor alarm at 75.0 % while braking
// RQ22: motor alarm at 75 % above full load
// RQ23: simultaneous trips take smallest priority number
`default_nettype none
module trip_priority_manager #(
    parameter int unsigned ACC_W = 16,
    parameter longint unsigned RESET_DELAY = trip_pkg::RESET_DELAY_CYC,
    parameter longint unsigned EXT_RESET_DELAY = trip_pkg::EXT_RESET_DELAY_CYC,
    parameter longint unsigned OVERHEAT_STOP = trip_pkg::OVERHEAT_STOP_CYC,
    parameter longint unsigned ALARM_FLASH = trip_pkg::ALARM_FLASH_CYC,
    parameter longint unsigned PROG_FLASH = trip_pkg::PROG_FLASH_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    // trip sources and operator
    input wire trip_pkg::trip_req_t trip_req_i,
    input wire logic reset_req_i,
    input wire logic defaults_code_written_i,
    input wire logic powering_up_i,
    // motor and supply state
    input wire logic motor_stopped_i,
    input wire logic [7:0] stop_on_trip_config_i,
    input wire logic undervoltage_condition_flag_i,
    input wire logic low_voltage_supply_mode_flag_i,
    input wire logic above_restart_level_i,
    input wire logic supply_switch_req_i,
    // alarm inputs
    input wire logic [ACC_W-1:0] resistor_heating_accumulator_i,
    input wire logic [ACC_W-1:0] resistor_trip_value_i,
    input wire logic braking_active_i,
    input wire logic [ACC_W-1:0] motor_heating_accumulator_i,
    input wire logic [ACC_W-1:0] motor_trip_value_i,
    input wire logic [7:0] drive_load_pct_i,
    input wire logic program_running_i,
    input wire logic param_editing_i,
    // outputs
    output logic tripped_o,
    output trip_pkg::trip_src_t trip_src_o,
    output logic [2:0] trip_prio_o,
    output logic undervoltage_trip_o,
    output logic drive_enable_block_o,
    output logic stop_req_o,
    output logic power_down_save_o,
    output logic supply_switch_ok_o,
    output trip_pkg::alarm_t alarm_show_o
);
    import trip_pkg::*;

    // refuse settings that the counters and the threshold product cannot serve
    if (ACC_W < 4 || ACC_W > 32 || RESET_DELAY < 1 || EXT_RESET_DELAY < 1 ||
        OVERHEAT_STOP < 1 || ALARM_FLASH < 2 || PROG_FLASH < 2) begin : g_param_check
        $error("trip_priority_manager: unsupported parameter");
    end

    trip_src_t src_reg;
    logic [2:0] prio_reg;
    logic [39:0] age_reg;
    logic first_reg;
    trip_src_t cand;
    logic [2:0] cand_prio;
    logic stop_pend_reg;
    trip_src_t stop_src_reg;
    logic [39:0] stop_age_reg;

    // smallest priority number wins among simultaneous requests [RQ23]
    always_comb begin
        cand = SRC_NONE;
        cand_prio = PRIO_NONE;
        if (trip_req_i.internal_hardware_fault) begin
            cand = SRC_HW;
            cand_prio = PRIO_HW;
        end else if (trip_req_i.nonresettable_fault) begin
            cand = SRC_NONRESET;
            cand_prio = PRIO_NONRESET;
        end else if (trip_req_i.nonvolatile_data_error_trip) begin
            cand = SRC_NVDATA;
            cand_prio = PRIO_NVDATA;
        end else if (trip_req_i.card_trip && !powering_up_i) begin
            cand = SRC_CARD;
            cand_prio = PRIO_CARD; // [RQ5]
        end else if (trip_req_i.encoder_supply_trip) begin
            cand = SRC_ENC_SUPPLY;
            cand_prio = PRIO_ENC_SUPPLY;
        end else if (trip_req_i.card_trip) begin
            cand = SRC_CARD;
            cand_prio = PRIO_CARD_PWRUP; // [RQ5]
        end else if (trip_req_i.extended_reset_trip) begin
            cand = SRC_EXT_RESET;
            cand_prio = PRIO_NORMAL;
        end else if (trip_req_i.encoder_feedback_trip) begin
            cand = SRC_ENC_FEEDBACK;
            cand_prio = PRIO_NORMAL;
        end else if (trip_req_i.normal_trip) begin
            cand = SRC_NORMAL;
            cand_prio = PRIO_NORMAL;
        end else if (stop_pend_reg && (motor_stopped_i || stop_age_reg >= OVERHEAT_STOP)) begin
            cand = stop_src_reg; // [RQ10] [RQ11]
            cand_prio = PRIO_NORMAL;
        end else if (trip_req_i.non_important_trip && !stop_on_trip_config_i[STOP_ON_TRIP_BIT]) begin
            cand = SRC_NON_IMPORTANT;
            cand_prio = PRIO_NORMAL;
        end else if (first_reg && !above_restart_level_i) begin
            cand = SRC_UNDERVOLT; // [RQ18]
            cand_prio = PRIO_UNDERVOLT;
        end else if (undervoltage_condition_flag_i) begin
            cand = SRC_UNDERVOLT;
            cand_prio = PRIO_UNDERVOLT;
        end
    end

    // accept over larger number; encoder supply over priority 5 only for feedback trips [RQ1] [RQ6]
    logic accept;
    assign accept = (cand != SRC_NONE) && (cand_prio < prio_reg) &&
        !(cand == SRC_ENC_SUPPLY && prio_reg == PRIO_NORMAL && src_reg != SRC_ENC_FEEDBACK);

    logic reset_ok;
    always_comb begin
        unique case (src_reg)
            SRC_HW, SRC_NONRESET, SRC_UNDERVOLT, SRC_NONE: reset_ok = 1'b0; // [RQ2] [RQ3] [RQ12]
            SRC_NVDATA: reset_ok = defaults_code_written_i && age_reg >= RESET_DELAY; // [RQ4]
            SRC_EXT_RESET: reset_ok = age_reg >= EXT_RESET_DELAY; // [RQ7]
            default: reset_ok = age_reg >= RESET_DELAY; // [RQ8]
        endcase
    end

    // restored supply clears undervoltage only [RQ15]
    logic undervolt_clear;
    assign undervolt_clear = src_reg == SRC_UNDERVOLT && above_restart_level_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            src_reg <= SRC_NONE;
            prio_reg <= PRIO_NONE;
            age_reg <= 40'h0;
        end else if (accept) begin
            src_reg <= cand;
            prio_reg <= cand_prio;
            age_reg <= 40'h0; // [RQ23]
        end else if ((reset_req_i && reset_ok) || undervolt_clear) begin
            src_reg <= SRC_NONE;
            prio_reg <= PRIO_NONE;
            age_reg <= 40'h0;
        end else if (src_reg != SRC_NONE && age_reg != 40'hff_ffff_ffff) begin
            age_reg <= age_reg + 40'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // stop before tripping for phase loss, overheat, configured non-important
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stop_pend_reg <= 1'b0;
            stop_src_reg <= SRC_NONE;
            stop_age_reg <= 40'h0;
        end else if (stop_pend_reg) begin
            if (accept || src_reg != SRC_NONE && prio_reg <= PRIO_NORMAL) begin
                stop_pend_reg <= 1'b0;
            end
            if (stop_age_reg != 40'hff_ffff_ffff) begin
                stop_age_reg <= stop_age_reg + 40'h1;
            end
        end else if (prio_reg > PRIO_NORMAL) begin
            stop_age_reg <= 40'h0;
            if (trip_req_i.thermal_model_overheat_trip) begin
                stop_pend_reg <= 1'b1; // [RQ11]
                stop_src_reg <= SRC_OVERHEAT;
            end else if (trip_req_i.phase_loss_trip) begin
                stop_pend_reg <= 1'b1; // [RQ10]
                stop_src_reg <= SRC_PHASE_LOSS;
            end else if (trip_req_i.non_important_trip && stop_on_trip_config_i[STOP_ON_TRIP_BIT]) begin
                stop_pend_reg <= 1'b1; // [RQ9]
                stop_src_reg <= SRC_NON_IMPORTANT;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tripped_o <= 1'b0;
            trip_src_o <= SRC_NONE;
            trip_prio_o <= PRIO_NONE;
            undervoltage_trip_o <= 1'b0;
            drive_enable_block_o <= 1'b1;
            stop_req_o <= 1'b0;
            power_down_save_o <= 1'b0;
            supply_switch_ok_o <= 1'b0;
        end else begin
            tripped_o <= src_reg != SRC_NONE;
            trip_src_o <= src_reg;
            trip_prio_o <= prio_reg;
            undervoltage_trip_o <= src_reg == SRC_UNDERVOLT; // [RQ17]
            drive_enable_block_o <= src_reg != SRC_NONE; // [RQ13]
            stop_req_o <= stop_pend_reg;
            power_down_save_o <= accept && cand == SRC_UNDERVOLT && !first_reg &&
                !low_voltage_supply_mode_flag_i; // [RQ14] [RQ18]
            supply_switch_ok_o <= supply_switch_req_i && undervoltage_condition_flag_i; // [RQ16]
        end
    end

    // alarms
    function automatic logic at_threshold(input logic [ACC_W-1:0] acc,
                                          input logic [ACC_W-1:0] lim);
        return 42'(acc) * 42'(1000) >= 42'(lim) * 42'(ALARM_PERMILLE);
    endfunction

    logic [39:0] flash_cnt_reg;
    logic [39:0] prog_cnt_reg;
    logic flash_on_reg;
    logic prog_on_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flash_cnt_reg <= 40'h0;
            flash_on_reg <= 1'b0;
        end else if (flash_cnt_reg >= ALARM_FLASH - 1) begin
            flash_cnt_reg <= 40'h0;
            flash_on_reg <= 1'b1; // [RQ19]
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 40'h1;
            if (flash_cnt_reg >= ALARM_FLASH / 2 - 1) begin
                flash_on_reg <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prog_cnt_reg <= 40'h0;
            prog_on_reg <= 1'b0;
        end else if (prog_cnt_reg >= PROG_FLASH - 1) begin
            prog_cnt_reg <= 40'h0;
            prog_on_reg <= 1'b1; // [RQ19]
        end else begin
            prog_cnt_reg <= prog_cnt_reg + 40'h1;
            if (prog_cnt_reg >= ALARM_FLASH / 2 - 1) begin
                prog_on_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            alarm_show_o <= '0;
        end else begin
            alarm_show_o.braking_resistor_overload_alarm <= !param_editing_i && flash_on_reg &&
                braking_active_i &&
                at_threshold(resistor_heating_accumulator_i, resistor_trip_value_i); // [RQ20] [RQ21]
            alarm_show_o.motor_overload_alarm <= !param_editing_i && flash_on_reg &&
                drive_load_pct_i > 8'(LOAD_FULL_PCT) &&
                at_threshold(motor_heating_accumulator_i, motor_trip_value_i); // [RQ20] [RQ22]
            alarm_show_o.program_running_alarm <= !param_editing_i && prog_on_reg &&
                program_running_i; // [RQ19] [RQ20]
        end
    end

    AST_HW_STICKS: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ2]
        src_reg == SRC_HW |=> src_reg == SRC_HW)
        else $error("hardware fault was cleared");
    AST_ACCEPT_ORDER: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ1]
        src_reg != $past(src_reg) && src_reg != SRC_NONE && $past(src_reg) != SRC_NONE
        |-> prio_reg < $past(prio_reg))
        else $error("trip replaced without smaller priority");
    AST_EARLY_RESET: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ8]
        src_reg == SRC_NORMAL && age_reg < RESET_DELAY && !accept |=> src_reg != SRC_NONE)
        else $error("normal trip cleared too early");
    AST_UNDERVOLT_NO_USER: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ12]
        src_reg == SRC_UNDERVOLT && !above_restart_level_i && !accept |=> src_reg == SRC_UNDERVOLT)
        else $error("undervoltage cleared by user");
    AST_SWITCH: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ16]
        supply_switch_ok_o |-> $past(undervoltage_condition_flag_i))
        else $error("supply switch outside undervoltage");
    AST_EDIT_QUIET: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ20]
        $past(param_editing_i) |-> alarm_show_o == '0)
        else $error("alarm shown while editing");
    AST_SAVE_LV: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ14]
        power_down_save_o |-> !$past(low_voltage_supply_mode_flag_i) && undervoltage_trip_o == 1'b0
        ##1 undervoltage_trip_o)
        else $error("save in low-voltage mode");
    AST_UNDERVOLT_ENABLE: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ13]
        undervoltage_trip_o |-> drive_enable_block_o)
        else $error("enable not blocked in undervoltage");
endmodule // trip_priority_manager
`default_nettype wire

/* File: tb/test_trip_priority_manager.sv */
`default_nettype none
module test_trip_priority_manager;
    timeunit 1ns;
    timeprecision 1ps;
    import trip_pkg::*;
    // shortened counts, all expectations derive from these
    localparam int RD = 10;
    localparam int ERD = 50;
    localparam int OHS = 30;
    localparam int AF = 8;
    localparam int PF = 40;
    logic clk_i, srst_i, reset_req_i, defaults_code_written_i, powering_up_i, motor_stopped_i;
    trip_req_t trip_req_i;
    logic [7:0] stop_on_trip_config_i, drive_load_pct_i;
    logic undervoltage_condition_flag_i, low_voltage_supply_mode_flag_i, above_restart_level_i;
    logic supply_switch_req_i, braking_active_i, program_running_i, param_editing_i;
    logic [15:0] resistor_heating_accumulator_i, resistor_trip_value_i;
    logic [15:0] motor_heating_accumulator_i, motor_trip_value_i;
    logic tripped_o, undervoltage_trip_o, drive_enable_block_o, stop_req_o;
    logic power_down_save_o, supply_switch_ok_o;
    trip_src_t trip_src_o;
    logic [2:0] trip_prio_o;
    alarm_t alarm_show_o;
    int miscompares = 0, check_count = 0, cycles = 0, saves = 0;

    trip_priority_manager #(.RESET_DELAY(RD), .EXT_RESET_DELAY(ERD), .OVERHEAT_STOP(OHS),
        .ALARM_FLASH(AF), .PROG_FLASH(PF)) trip_priority_manager_i (.clk_i(clk_i),
        .srst_i(srst_i), .trip_req_i(trip_req_i), .reset_req_i(reset_req_i),
        .defaults_code_written_i(defaults_code_written_i), .powering_up_i(powering_up_i),
        .motor_stopped_i(motor_stopped_i), .stop_on_trip_config_i(stop_on_trip_config_i),
        .undervoltage_condition_flag_i(undervoltage_condition_flag_i),
        .low_voltage_supply_mode_flag_i(low_voltage_supply_mode_flag_i),
        .above_restart_level_i(above_restart_level_i), .supply_switch_req_i(supply_switch_req_i),
        .resistor_heating_accumulator_i(resistor_heating_accumulator_i),
        .resistor_trip_value_i(resistor_trip_value_i), .braking_active_i(braking_active_i),
        .motor_heating_accumulator_i(motor_heating_accumulator_i),
        .motor_trip_value_i(motor_trip_value_i), .drive_load_pct_i(drive_load_pct_i),
        .program_running_i(program_running_i), .param_editing_i(param_editing_i),
        .tripped_o(tripped_o), .trip_src_o(trip_src_o), .trip_prio_o(trip_prio_o),
        .undervoltage_trip_o(undervoltage_trip_o), .drive_enable_block_o(drive_enable_block_o),
        .stop_req_o(stop_req_o), .power_down_save_o(power_down_save_o),
        .supply_switch_ok_o(supply_switch_ok_o), .alarm_show_o(alarm_show_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic stop_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog and save pulse counter
    always @(posedge clk_i) begin
        cycles++;
        if (power_down_save_o === 1'b1) saves++;
        if (cycles >= 8000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_trip(input logic tr, input logic [2:0] prio, input trip_src_t src);
        chk("tripped_o", 16'(tr), 16'(tripped_o));
        chk("trip_prio_o", 16'(prio), 16'(trip_prio_o));
        chk("trip_src_o", 16'(src), 16'(trip_src_o));
    endtask

    task automatic do_reset(input logic above);
        srst_i = 1'b1;
        trip_req_i = '0;
        {reset_req_i, defaults_code_written_i, powering_up_i, motor_stopped_i} = 4'h0;
        stop_on_trip_config_i = 8'h00;
        {undervoltage_condition_flag_i, low_voltage_supply_mode_flag_i} = 2'h0;
        supply_switch_req_i = 1'b0;
        above_restart_level_i = above;
        tick(10);
        srst_i = 1'b0;
        tick(3);
    endtask

    task automatic pulse_reset();
        reset_req_i = 1'b1;
        tick(1);
        reset_req_i = 1'b0;
        tick(2);
    endtask

    task automatic t_normal();
        do_reset(1'b1);
        chk("drive_enable_block_o", 16'h0000, 16'(drive_enable_block_o));
        trip_req_i.normal_trip = 1'b1;
        tick(2);
        trip_req_i.normal_trip = 1'b0;
        chk_trip(1'b1, PRIO_NORMAL, SRC_NORMAL);
        chk("drive_enable_block_o", 16'h0001, 16'(drive_enable_block_o));
        pulse_reset();
        chk_trip(1'b1, PRIO_NORMAL, SRC_NORMAL);
        tick(RD);
        pulse_reset();
        chk_trip(1'b0, PRIO_NONE, SRC_NONE);
        trip_req_i.extended_reset_trip = 1'b1;
        tick(2);
        trip_req_i.extended_reset_trip = 1'b0;
        tick(2 * RD);
        pulse_reset();
        chk_trip(1'b1, PRIO_NORMAL, SRC_EXT_RESET);
        tick(ERD);
        pulse_reset();
        chk_trip(1'b0, PRIO_NONE, SRC_NONE);
    endtask

    task automatic t_prio();
        do_reset(1'b1);
        trip_req_i.nonvolatile_data_error_trip = 1'b1;
        tick(2);
        trip_req_i.nonvolatile_data_error_trip = 1'b0;
        trip_req_i.normal_trip = 1'b1;
        tick(3);
        trip_req_i.normal_trip = 1'b0;
        chk_trip(1'b1, PRIO_NVDATA, SRC_NVDATA);
        tick(RD);
        pulse_reset();
        chk_trip(1'b1, PRIO_NVDATA, SRC_NVDATA);
        defaults_code_written_i = 1'b1;
        pulse_reset();
        chk_trip(1'b0, PRIO_NONE, SRC_NONE);
        defaults_code_written_i = 1'b0;
        // three sources in one cycle
        trip_req_i.internal_hardware_fault = 1'b1;
        trip_req_i.nonresettable_fault = 1'b1;
        trip_req_i.normal_trip = 1'b1;
        tick(2);
        trip_req_i = '0;
        chk_trip(1'b1, PRIO_HW, SRC_HW);
        tick(RD);
        pulse_reset();
        chk_trip(1'b1, PRIO_HW, SRC_HW);
        do_reset(1'b1);
        trip_req_i.nonresettable_fault = 1'b1;
        tick(2);
        trip_req_i = '0;
        tick(RD);
        pulse_reset();
        chk_trip(1'b1, PRIO_NONRESET, SRC_NONRESET);
    endtask

    task automatic t_enc_card();
        for (int k = 0; k < 2; k++) begin
            do_reset(1'b1);
            trip_req_i.normal_trip = (k == 0);
            trip_req_i.encoder_feedback_trip = (k == 1);
            tick(2);
            trip_req_i.encoder_supply_trip = 1'b1;
            tick(3);
            if (k == 0) chk_trip(1'b1, PRIO_NORMAL, SRC_NORMAL);
            else chk_trip(1'b1, PRIO_ENC_SUPPLY, SRC_ENC_SUPPLY);
            do_reset(1'b1);
            powering_up_i = (k == 0);
            trip_req_i.card_trip = 1'b1;
            tick(3);
            if (k == 0) chk_trip(1'b1, PRIO_CARD_PWRUP, SRC_CARD);
            else chk_trip(1'b1, PRIO_CARD, SRC_CARD);
        end
    endtask

    task automatic t_stop();
        for (int k = 0; k < 3; k++) begin
            do_reset(1'b1);
            stop_on_trip_config_i = (k == 2) ? 8'h01 : 8'h00;
            if (k == 0) trip_req_i.phase_loss_trip = 1'b1;
            else trip_req_i.non_important_trip = 1'b1;
            tick(3);
            if (k == 1) begin
                chk_trip(1'b1, PRIO_NORMAL, SRC_NON_IMPORTANT);
            end else begin
                chk("stop_req_o", 16'h0001, 16'(stop_req_o));
                chk("tripped_o", 16'h0000, 16'(tripped_o));
                motor_stopped_i = 1'b1;
                tick(3);
                chk("tripped_o", 16'h0001, 16'(tripped_o));
            end
        end
        do_reset(1'b1);
        trip_req_i.thermal_model_overheat_trip = 1'b1;
        tick(OHS - 5);
        chk("stop_req_o", 16'h0001, 16'(stop_req_o));
        chk("tripped_o", 16'h0000, 16'(tripped_o));
        tick(10);
        chk_trip(1'b1, PRIO_NORMAL, SRC_OVERHEAT);
    endtask

    task automatic t_undervolt();
        int s0;
        s0 = saves;
        do_reset(1'b0);
        chk_trip(1'b1, PRIO_UNDERVOLT, SRC_UNDERVOLT);
        chk("saves", 16'(s0), 16'(saves));
        tick(RD);
        pulse_reset();
        chk("undervoltage_trip_o", 16'h0001, 16'(undervoltage_trip_o));
        above_restart_level_i = 1'b1;
        tick(3);
        chk_trip(1'b0, PRIO_NONE, SRC_NONE);
        for (int m = 0; m < 2; m++) begin
            low_voltage_supply_mode_flag_i = (m == 1);
            s0 = saves;
            supply_switch_req_i = 1'b1;
            tick(2);
            chk("supply_switch_ok_o", 16'h0000, 16'(supply_switch_ok_o));
            undervoltage_condition_flag_i = 1'b1;
            above_restart_level_i = 1'b0;
            tick(4);
            chk("undervoltage_trip_o", 16'h0001, 16'(undervoltage_trip_o));
            chk("drive_enable_block_o", 16'h0001, 16'(drive_enable_block_o));
            chk("saves", 16'(s0 + 1 - m), 16'(saves));
            chk("supply_switch_ok_o", 16'h0001, 16'(supply_switch_ok_o));
            if (m == 1) begin
                trip_req_i.normal_trip = 1'b1;
                tick(2);
                trip_req_i.normal_trip = 1'b0;
                chk_trip(1'b1, PRIO_NORMAL, SRC_NORMAL);
                chk("undervoltage_trip_o", 16'h0000, 16'(undervoltage_trip_o));
            end
            undervoltage_condition_flag_i = 1'b0;
            above_restart_level_i = 1'b1;
            tick(3);
            chk("supply_switch_ok_o", 16'h0000, 16'(supply_switch_ok_o));
            chk("tripped_o", 16'(m), 16'(tripped_o));
            supply_switch_req_i = 1'b0;
        end
    endtask

    // counts flash-high cycles of each alarm over one program flash period
    task automatic alarm_case(input logic [15:0] racc, input logic brk, input logic [15:0] macc,
        input logic [7:0] load, input logic prog, input logic edit, input int er, input int em,
        input int ep);
        int hr, hm, hp;
        {hr, hm, hp} = '0;
        resistor_heating_accumulator_i = racc;
        braking_active_i = brk;
        motor_heating_accumulator_i = macc;
        drive_load_pct_i = load;
        program_running_i = prog;
        param_editing_i = edit;
        tick(3);
        repeat (PF) begin
            tick(1);
            hr += int'(alarm_show_o.braking_resistor_overload_alarm === 1'b1);
            hm += int'(alarm_show_o.motor_overload_alarm === 1'b1);
            hp += int'(alarm_show_o.program_running_alarm === 1'b1);
        end
        chk("resistor_alarm_flashes", 16'(er), 16'(hr));
        chk("motor_alarm_flashes", 16'(em), 16'(hm));
        chk("program_alarm_flashes", 16'(ep), 16'(hp));
    endtask

    task automatic t_alarm();
        do_reset(1'b1);
        alarm_case(16'd750, 1'b1, 16'd750, 8'd101, 1'b1, 1'b0, PF / 2, PF / 2, AF / 2);
        alarm_case(16'd749, 1'b1, 16'd749, 8'd101, 1'b0, 1'b0, 0, 0, 0);
        alarm_case(16'd750, 1'b0, 16'd750, 8'd100, 1'b0, 1'b0, 0, 0, 0);
        alarm_case(16'd750, 1'b1, 16'd750, 8'd101, 1'b1, 1'b1, 0, 0, 0);
    endtask

    initial begin
        srst_i = 1'b1;
        trip_req_i = '0;
        {reset_req_i, defaults_code_written_i, powering_up_i, motor_stopped_i} = 4'h0;
        stop_on_trip_config_i = 8'h00;
        {undervoltage_condition_flag_i, low_voltage_supply_mode_flag_i} = 2'h0;
        {above_restart_level_i, supply_switch_req_i} = 2'h2;
        {braking_active_i, program_running_i, param_editing_i} = 3'h0;
        resistor_heating_accumulator_i = 16'h0000;
        resistor_trip_value_i = 16'h03e8;
        motor_heating_accumulator_i = 16'h0000;
        motor_trip_value_i = 16'h03e8;
        drive_load_pct_i = 8'h00;
        t_normal();
        t_prio();
        t_enc_card();
        t_stop();
        t_undervolt();
        t_alarm();
        stop_test();
    end
endmodule // test_trip_priority_manager
`default_nettype wire
